// ==== shared/fri_pkg.sv ====
// Operation
// - Main array is 128 pages of 2 Kbyte in 64-bit cells.
// - Instruction prefetch buffer holds two 64-bit blocks.
// - Only instruction fetches use prefetch; data reads bypass it.
// - Data reads win arbitration over instruction and prefetch reads.
// - Prefetch reads are issued whenever one buffer block is free.
// - Prefetch enable resets on, at bit 4 of access control.
// - Read strobes held 0 to 2 wait states; field resets to zero.
// - Flash reads stall during program or erase, then complete.
// - After reset control writes are ignored except option reload trigger.
// - Two keys in order unlock control register writes.
// - A wrong key sequence locks the controller until reset.
// - A wrong first or second key raises an error.
// - Writing the lock bit relocks controller and control register.
// - Half-word write with programming enabled starts a program.
// - Non half-word array write while programming enabled gives error.
// - Non-erased target skips programming with error, except zero data.
// - Write-protected target skips program or page erase with protect error; mass erase ignores protection.
// - End-of-operation flag set on completion; software clears it.
// - Control writes are ignored while busy.
// - Page erase uses address, then page select with start in one write; busy meanwhile.
// - Mass erase uses mass select with start in one write; erases user pages.
package fri_pkg;
   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int PAGE_COUNT = 128;
   localparam int PAGE_BYTES = 2048;
   localparam int ADDR_W = 18;
   localparam int WADDR_W = 15;
   localparam int PAGE_W = 7;
   localparam int SECT_W = 5;
   localparam int PAGE_LSB = 11;
   localparam int SECT_LSB = 13;
   localparam int SECT_COUNT = 32;
   localparam int BLK_W = 64;
   localparam int PF_BLOCKS = 2;
   // ----------------------------------------
   // Access control register
   // ----------------------------------------
   localparam int ACR_W = 8;
   localparam int ACR_PFE_BIT = 4;
   localparam logic [ACR_W-1:0] ACR_RESET = 8'h10;
   localparam logic [2:0] LAT_MAX = 3'h2;
   // ----------------------------------------
   // Control register and keys
   // ----------------------------------------
   localparam int CR_W = 16;
   localparam int CR_PG_BIT = 0;
   localparam int CR_PER_BIT = 1;
   localparam int CR_MER_BIT = 2;
   localparam int CR_ERASE_START_BIT = 6;
   localparam int CR_LOCK_BIT = 7;
   localparam int CR_RELOAD_BIT = 13;
   localparam logic [CR_W-1:0] CR_KEEP = 16'h0007;
   localparam logic [CR_W-1:0] CR_RESET = 16'h0000;
   localparam logic [31:0] FIRST_UNLOCK_KEY = 32'h4567_0123;
   localparam logic [31:0] SECOND_UNLOCK_KEY = 32'hCDEF_89AB;
   localparam logic [15:0] HW_ERASED = 16'hFFFF;
   localparam logic [15:0] HW_ZERO = 16'h0000;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   // ----------------------------------------
   // States
   // ----------------------------------------
   typedef enum logic [1:0] {
      FRI_KEY_FIRST = 2'b00,
      FRI_KEY_SECOND = 2'b01,
      FRI_KEY_OPEN = 2'b10,
      FRI_KEY_DEAD = 2'b11
   } fri_key_t;
   typedef enum logic [2:0] {
      FRI_PE_IDLE = 3'b000,
      FRI_PE_CHECK = 3'b001,
      FRI_PE_WAIT = 3'b010,
      FRI_PE_PROG = 3'b011,
      FRI_PE_ERASE = 3'b100
   } fri_pe_t;
   typedef enum logic [1:0] {
      FRI_SRC_PE = 2'b00,
      FRI_SRC_DATA = 2'b01,
      FRI_SRC_INSTR = 2'b10,
      FRI_SRC_PREF = 2'b11
   } fri_src_t;
endpackage : fri_pkg

// ==== hdl/fri_read_engine.sv ====
`timescale 1ns/1ps
module fri_read_engine
   import fri_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic [WADDR_W-1:0] addr,
   input wire logic [2:0] latency,
   input wire logic [BLK_W-1:0] arr_rdata,
   output logic rd_en_q,
   output logic [WADDR_W-1:0] addr_q,
   output logic done_q,
   output logic [BLK_W-1:0] data_q
);
   // ----------------------------------------
   // Wait-state counter
   // ----------------------------------------
   logic [2:0] cnt_q;
   logic [2:0] lat_eff;
   logic last;

   assign lat_eff = (latency > LAT_MAX) ? LAT_MAX : latency;
   assign last = rd_en_q && (cnt_q == 3'h0);

   always_ff @(posedge clock) begin
      if (reset) begin
         rd_en_q <= 1'b0;
         addr_q <= '0;
         done_q <= 1'b0;
         data_q <= '0;
         cnt_q <= 3'h0;
      end else begin
         done_q <= last;
         if (start && !rd_en_q) begin
            rd_en_q <= 1'b1;
            addr_q <= addr;
            cnt_q <= lat_eff;
         end else if (last) begin
            rd_en_q <= 1'b0;
            data_q <= arr_rdata;
         end else if (rd_en_q) begin
            cnt_q <= cnt_q - 3'h1;
         end
      end
   end
endmodule : fri_read_engine

// ==== hdl/fri_flash_if.sv ====
`timescale 1ns/1ps
module fri_flash_if
   import fri_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic ifetch_req,
   input wire logic [ADDR_W-1:0] ifetch_addr,
   output logic ifetch_ready,
   output logic [31:0] ifetch_rdata,
   input wire logic dfetch_req,
   input wire logic dfetch_write,
   input wire logic [1:0] dfetch_size,
   input wire logic [ADDR_W-1:0] dfetch_addr,
   input wire logic [31:0] dfetch_wdata,
   output logic dfetch_ready,
   output logic dfetch_error,
   output logic [31:0] dfetch_rdata,
   input wire logic acr_wr,
   input wire logic [ACR_W-1:0] acr_wdata,
   output logic [ACR_W-1:0] acr_value,
   input wire logic key_wr,
   input wire logic [31:0] key_wdata,
   output logic key_error,
   input wire logic ctrl_wr,
   input wire logic [CR_W-1:0] ctrl_wdata,
   output logic [CR_W-1:0] ctrl_value,
   output logic locked,
   output logic option_reload_trigger,
   input wire logic ear_wr,
   input wire logic [ADDR_W-1:0] ear_wdata,
   input wire logic clr_eop,
   input wire logic clr_programming_error_flag,
   input wire logic clr_wrperr,
   output logic busy_flag,
   output logic end_of_operation_flag,
   output logic programming_error_flag,
   output logic write_protect_error_flag,
   input wire logic [SECT_COUNT-1:0] wrp_sector,
   output logic arr_rd_en,
   output logic [WADDR_W-1:0] arr_addr,
   input wire logic [BLK_W-1:0] arr_rdata,
   output logic arr_prog,
   output logic [ADDR_W-2:0] arr_prog_addr,
   output logic [15:0] arr_prog_data,
   output logic arr_page_erase,
   output logic arr_mass_erase,
   output logic [PAGE_W-1:0] arr_erase_page,
   input wire logic arr_done
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   fri_key_t key_q;
   fri_key_t key_d;
   fri_pe_t pe_q;
   fri_pe_t pe_d;
   fri_src_t src_q;
   fri_src_t src_d;
   logic [ACR_W-1:0] acr_q;
   logic [CR_W-1:0] ctrl_q;
   logic [ADDR_W-1:0] ear_q;
   logic [ADDR_W-1:0] padr_q;
   logic [15:0] pdat_q;
   logic busy_q, eop_q, programming_error_flag_q, wrperr_q, keyerr_q, reload_q, locked_q;
   logic prog_q, perase_q, merase_q;
   logic iready_q, dready_q, derr_q, dpend_q, ipend_q;
   logic [31:0] irdata_q, drdata_q;
   logic [WADDR_W-1:0] next_q;
   logic fill_q;
   logic [PF_BLOCKS-1:0] valid_q;
   logic [WADDR_W-1:0] tag_q [PF_BLOCKS];
   logic [BLK_W-1:0] blk_q [PF_BLOCKS];
   logic eng_act, eng_done, eng_start, eng_start_q;
   logic [WADDR_W-1:0] eng_addr, eng_raddr;
   logic [BLK_W-1:0] eng_data;

   // ----------------------------------------
   // Register and key decode
   // ----------------------------------------
   logic is_open, cw_ok, kw_ok, key_match, key_bad, relock, reload_go;
   logic erase_start_go, erase_go, erase_prot;
   logic [CR_W-1:0] ctrl_d;

   assign is_open = (key_q == FRI_KEY_OPEN);
   assign cw_ok = ctrl_wr && !busy_q;
   assign kw_ok = key_wr && !busy_q;
   assign key_match = (key_q == FRI_KEY_FIRST) ? (key_wdata == FIRST_UNLOCK_KEY)
                                               : (key_wdata == SECOND_UNLOCK_KEY);
   assign key_bad = kw_ok && !(key_match && (key_q != FRI_KEY_OPEN) && (key_q != FRI_KEY_DEAD));
   assign relock = cw_ok && is_open && ctrl_wdata[CR_LOCK_BIT];
   assign reload_go = cw_ok && ctrl_wdata[CR_RELOAD_BIT];
   assign erase_start_go = cw_ok && is_open && !relock && ctrl_wdata[CR_ERASE_START_BIT];
   assign erase_go = erase_start_go && (ctrl_wdata[CR_PER_BIT] || ctrl_wdata[CR_MER_BIT]);
   assign erase_prot = ctrl_wdata[CR_PER_BIT] && wrp_sector[ear_q[ADDR_W-1:SECT_LSB]];
   assign ctrl_d = relock ? CR_RESET : (ctrl_wdata & CR_KEEP);

   always_comb begin
      key_d = key_q;
      if (relock) begin
         key_d = FRI_KEY_FIRST;
      end else if (key_bad) begin
         key_d = FRI_KEY_DEAD;
      end else if (kw_ok) begin
         case (key_q)
            FRI_KEY_FIRST: key_d = FRI_KEY_SECOND;
            FRI_KEY_SECOND: key_d = FRI_KEY_OPEN;
            default: key_d = key_q;
         endcase
      end
   end

   // ----------------------------------------
   // Data bus decode
   // ----------------------------------------
   logic d_idle, d_rd, d_wr, pg_on, d_size_bad, prog_go;

   assign d_idle = dfetch_req && !dready_q;
   assign d_rd = d_idle && !dfetch_write && !dpend_q && !busy_q;
   assign d_wr = d_idle && dfetch_write && !busy_q;
   assign pg_on = is_open && ctrl_q[CR_PG_BIT];
   assign d_size_bad = d_wr && pg_on && (dfetch_size != SIZE_HALF);
   assign prog_go = d_wr && pg_on && (dfetch_size == SIZE_HALF);

   // ----------------------------------------
   // Prefetch buffer hit and arbitration
   // ----------------------------------------
   logic [PF_BLOCKS-1:0] hit;
   logic any_hit, hit_sel, i_ack, i_miss, pf_req, pe_req, free_slot, eng_idle;

   assign any_hit = |hit;
   assign hit_sel = hit[1];
   assign i_ack = ifetch_req && !iready_q && any_hit;
   assign i_miss = ifetch_req && !iready_q && !any_hit && !ipend_q && !busy_q;
   assign pf_req = acr_q[ACR_PFE_BIT] && !(&valid_q) && !busy_q;
   assign pe_req = (pe_q == FRI_PE_CHECK) && !wrp_sector[padr_q[ADDR_W-1:SECT_LSB]];
   assign free_slot = valid_q[0];
   assign eng_idle = !eng_act && !eng_done && !eng_start_q;

   always_comb begin
      src_d = src_q;
      eng_start = 1'b0;
      eng_addr = next_q;
      if (eng_idle) begin
         if (pe_req) begin
            src_d = FRI_SRC_PE;
            eng_start = 1'b1;
            eng_addr = padr_q[ADDR_W-1:3];
         end else if (d_rd) begin
            src_d = FRI_SRC_DATA;
            eng_start = 1'b1;
            eng_addr = dfetch_addr[ADDR_W-1:3];
         end else if (i_miss) begin
            src_d = FRI_SRC_INSTR;
            eng_start = 1'b1;
            eng_addr = ifetch_addr[ADDR_W-1:3];
         end else if (pf_req) begin
            src_d = FRI_SRC_PREF;
            eng_start = 1'b1;
            eng_addr = next_q;
         end
      end
   end

   logic fill_go, d_done;

   assign fill_go = eng_done && ((src_q == FRI_SRC_INSTR) || (src_q == FRI_SRC_PREF));
   assign d_done = eng_done && (src_q == FRI_SRC_DATA);

   // ----------------------------------------
   // Prefetch blocks
   // ----------------------------------------
   genvar e;
   generate
      for (e = 0; e < PF_BLOCKS; e++) begin : g_blk
         logic flush, take, used;
         assign hit[e] = valid_q[e] && (tag_q[e] == ifetch_addr[ADDR_W-1:3]);
         assign flush = eng_start && (src_d == FRI_SRC_INSTR);
         assign take = fill_go && (fill_q == 1'(e));
         assign used = i_ack && hit[e] && ifetch_addr[2];
         always_ff @(posedge clock) begin
            if (reset) begin
               valid_q[e] <= 1'b0;
               tag_q[e] <= '0;
               blk_q[e] <= '0;
            end else begin
               if (flush || used) begin
                  valid_q[e] <= 1'b0;
               end else if (take) begin
                  valid_q[e] <= 1'b1;
                  tag_q[e] <= eng_raddr;
                  blk_q[e] <= eng_data;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read engine
   // ----------------------------------------
   fri_read_engine u_eng (
      .clock(clock),
      .reset(reset),
      .start(eng_start),
      .addr(eng_addr),
      .latency(acr_q[2:0]),
      .arr_rdata(arr_rdata),
      .rd_en_q(eng_act),
      .addr_q(eng_raddr),
      .done_q(eng_done),
      .data_q(eng_data)
   );

   // ----------------------------------------
   // Program and erase sequencer
   // ----------------------------------------
   logic [15:0] old_hw;
   logic prot_hit, not_erased, wrperr_set, programming_error_flag_set, eop_set;

   assign old_hw = eng_data[{padr_q[2:1], 4'h0} +: 16];
   assign prot_hit = (pe_q == FRI_PE_CHECK) && wrp_sector[padr_q[ADDR_W-1:SECT_LSB]];
   assign not_erased = (old_hw != HW_ERASED) && (pdat_q != HW_ZERO);
   assign programming_error_flag_set = (pe_q == FRI_PE_WAIT) && eng_done && (src_q == FRI_SRC_PE) && not_erased;
   assign wrperr_set = prot_hit || (erase_go && erase_prot);
   assign eop_set = ((pe_q == FRI_PE_PROG) || (pe_q == FRI_PE_ERASE)) && arr_done;

   always_comb begin
      pe_d = pe_q;
      case (pe_q)
         FRI_PE_IDLE: begin
            if (prog_go) begin
               pe_d = FRI_PE_CHECK;
            end else if (erase_go && !erase_prot) begin
               pe_d = FRI_PE_ERASE;
            end
         end
         FRI_PE_CHECK: begin
            if (prot_hit) begin
               pe_d = FRI_PE_IDLE;
            end else if (eng_start) begin
               pe_d = FRI_PE_WAIT;
            end
         end
         FRI_PE_WAIT: begin
            if (eng_done && (src_q == FRI_SRC_PE)) begin
               pe_d = not_erased ? FRI_PE_IDLE : FRI_PE_PROG;
            end
         end
         FRI_PE_PROG: pe_d = arr_done ? FRI_PE_IDLE : FRI_PE_PROG;
         FRI_PE_ERASE: pe_d = arr_done ? FRI_PE_IDLE : FRI_PE_ERASE;
         default: pe_d = FRI_PE_IDLE;
      endcase
   end

   // ----------------------------------------
   // Control and status registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         key_q <= FRI_KEY_FIRST;
         locked_q <= 1'b1;
         acr_q <= ACR_RESET;
         ctrl_q <= CR_RESET;
         ear_q <= '0;
         keyerr_q <= 1'b0;
         reload_q <= 1'b0;
      end else begin
         key_q <= key_d;
         locked_q <= (key_d != FRI_KEY_OPEN);
         keyerr_q <= key_bad;
         reload_q <= reload_go;
         if (acr_wr) begin
            acr_q <= acr_wdata;
         end
         if (cw_ok && is_open) begin
            ctrl_q <= ctrl_d;
         end
         if (ear_wr && !busy_q) begin
            ear_q <= ear_wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         pe_q <= FRI_PE_IDLE;
         busy_q <= 1'b0;
         padr_q <= '0;
         pdat_q <= HW_ZERO;
         eop_q <= 1'b0;
         programming_error_flag_q <= 1'b0;
         wrperr_q <= 1'b0;
      end else begin
         pe_q <= pe_d;
         busy_q <= (pe_d != FRI_PE_IDLE);
         if (prog_go) begin
            padr_q <= dfetch_addr;
            pdat_q <= dfetch_addr[1] ? dfetch_wdata[31:16] : dfetch_wdata[15:0];
         end
         eop_q <= eop_set || (eop_q && !clr_eop);
         programming_error_flag_q <= programming_error_flag_set || (programming_error_flag_q && !clr_programming_error_flag);
         wrperr_q <= wrperr_set || (wrperr_q && !clr_wrperr);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prog_q <= 1'b0;
         perase_q <= 1'b0;
         merase_q <= 1'b0;
      end else begin
         prog_q <= (pe_d == FRI_PE_PROG);
         perase_q <= (pe_d == FRI_PE_ERASE) && ((pe_q == FRI_PE_IDLE) ?
                     (ctrl_wdata[CR_PER_BIT] && !ctrl_wdata[CR_MER_BIT]) : perase_q);
         merase_q <= (pe_d == FRI_PE_ERASE) && ((pe_q == FRI_PE_IDLE) ?
                     ctrl_wdata[CR_MER_BIT] : merase_q);
      end
   end

   // ----------------------------------------
   // Read answers and prefetch pointer
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         src_q <= FRI_SRC_PE;
         eng_start_q <= 1'b0;
         fill_q <= 1'b0;
         next_q <= '0;
         ipend_q <= 1'b0;
         dpend_q <= 1'b0;
         iready_q <= 1'b0;
         irdata_q <= '0;
         dready_q <= 1'b0;
         derr_q <= 1'b0;
         drdata_q <= '0;
      end else begin
         src_q <= src_d;
         eng_start_q <= eng_start;
         if (eng_start && (src_d != FRI_SRC_PE) && (src_d != FRI_SRC_DATA)) begin
            fill_q <= (src_d == FRI_SRC_INSTR) ? 1'b0 : free_slot;
            next_q <= eng_addr + 15'h0001;
         end
         ipend_q <= (ipend_q || (eng_start && (src_d == FRI_SRC_INSTR))) && !fill_go;
         dpend_q <= (dpend_q || (eng_start && (src_d == FRI_SRC_DATA))) && !d_done;
         iready_q <= i_ack;
         if (i_ack) begin
            irdata_q <= blk_q[hit_sel][{ifetch_addr[2], 5'h00} +: 32];
         end
         dready_q <= d_done || d_wr;
         derr_q <= d_size_bad;
         if (d_done) begin
            drdata_q <= eng_data[{dfetch_addr[2], 5'h00} +: 32];
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ifetch_ready = iready_q;
   assign ifetch_rdata = irdata_q;
   assign dfetch_ready = dready_q;
   assign dfetch_error = derr_q;
   assign dfetch_rdata = drdata_q;
   assign acr_value = acr_q;
   assign key_error = keyerr_q;
   assign ctrl_value = ctrl_q;
   assign locked = locked_q;
   assign option_reload_trigger = reload_q;
   assign busy_flag = busy_q;
   assign end_of_operation_flag = eop_q;
   assign programming_error_flag = programming_error_flag_q;
   assign write_protect_error_flag = wrperr_q;
   assign arr_rd_en = eng_act;
   assign arr_addr = eng_raddr;
   assign arr_prog = prog_q;
   assign arr_prog_addr = padr_q[ADDR_W-1:1];
   assign arr_prog_data = pdat_q;
   assign arr_page_erase = perase_q;
   assign arr_mass_erase = merase_q;
   assign arr_erase_page = ear_q[ADDR_W-1:PAGE_LSB];
endmodule : fri_flash_if

// ==== bench/fri_array_model.sv ====
`timescale 1ns/1ps
// ---
// Array stand-in
// ---
module fri_array_model
   import fri_pkg::*;
#(parameter int DONE_WAIT = 20)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic arr_rd_en,
   input wire logic [WADDR_W-1:0] arr_addr,
   input wire logic arr_prog,
   input wire logic arr_page_erase,
   input wire logic arr_mass_erase,
   output logic [BLK_W-1:0] arr_rdata,
   output logic arr_done
);
   logic [7:0] wait_q;
   logic [BLK_W-1:0] pat;
   logic run;
   // Odd words hold a pattern, even words read erased
   assign pat = arr_addr[0] ? {4{1'b0, arr_addr}} : '1;
   // Idle read lines show the inverse
   assign arr_rdata = arr_rd_en ? pat : ~pat;
   assign run = arr_prog | arr_page_erase | arr_mass_erase;
   always_ff @(posedge clock) begin
      wait_q <= (reset | !run | arr_done) ? 8'h00 : wait_q + 8'h01;
      arr_done <= !reset & run & !arr_done & (wait_q == 8'(DONE_WAIT));
   end
endmodule : fri_array_model

// ==== bench/fri_flash_if_checker.sv ====
`timescale 1ns/1ps
// ---
// Port checks
// ---
module fri_flash_if_checker
   import fri_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [ACR_W-1:0] acr_value,
   input wire logic arr_rd_en,
   input wire logic busy_flag,
   input wire logic dfetch_ready,
   input wire logic key_wr,
   input wire logic [31:0] key_wdata,
   input wire logic key_error,
   input wire logic locked,
   input wire logic ctrl_wr,
   input wire logic [CR_W-1:0] ctrl_wdata,
   input wire logic [CR_W-1:0] ctrl_value,
   input wire logic end_of_operation_flag,
   input wire logic clr_eop,
   input wire logic arr_prog,
   input wire logic arr_done
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_read_start;
      $rose(arr_rd_en);
   endsequence
   sequence s_hold_three;
      arr_rd_en [*3] ##1 !arr_rd_en;
   endsequence
   a_lat_zero: assert property (s_read_start and $past(acr_value[2:0]) == 3'h0 |=> !arr_rd_en)
      else $error("read strobe too long");
   a_lat_two: assert property (s_read_start and $past(acr_value[2:0]) >= LAT_MAX |-> s_hold_three)
      else $error("read strobe hold wrong");
   a_stall_read: assert property ($past(busy_flag) && busy_flag |-> !dfetch_ready)
      else $error("data answered while busy");
   a_bad_key: assert property (key_wr && !busy_flag && locked && key_wdata != FIRST_UNLOCK_KEY
      && key_wdata != SECOND_UNLOCK_KEY |=> key_error)
      else $error("bad key not flagged");
   a_dead_lock: assert property (key_error |-> locked ##1 locked [*8])
      else $error("unlocked after bad key");
   a_key_open: assert property ($fell(locked) |-> $past(key_wr)
      && $past(key_wdata) == SECOND_UNLOCK_KEY)
      else $error("unlock without second key");
   a_ctrl_locked: assert property (locked && ctrl_wr |=> ctrl_value == $past(ctrl_value))
      else $error("control written while locked");
   a_lock_bit: assert property (ctrl_wr && ctrl_wdata[CR_LOCK_BIT] && !busy_flag |=> locked)
      else $error("lock bit ignored");
   a_prog_end: assert property (arr_prog && arr_done |=> !busy_flag && end_of_operation_flag)
      else $error("program end wrong");
   a_eop_hold: assert property (end_of_operation_flag && !clr_eop |=> end_of_operation_flag)
      else $error("end flag lost");
endmodule : fri_flash_if_checker
bind fri_flash_if fri_flash_if_checker chk_i (.clock(clock), .reset(reset),
   .acr_value(acr_value), .arr_rd_en(arr_rd_en), .busy_flag(busy_flag),
   .dfetch_ready(dfetch_ready), .key_wr(key_wr), .key_wdata(key_wdata),
   .key_error(key_error), .locked(locked), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
   .ctrl_value(ctrl_value), .end_of_operation_flag(end_of_operation_flag),
   .clr_eop(clr_eop), .arr_prog(arr_prog), .arr_done(arr_done));

// ==== bench/tb_flash_read_and_program_interface.sv ====
`timescale 1ns/1ps
module tb_flash_read_and_program_interface;
   import fri_pkg::*;
   typedef struct packed {
      logic ins;
      logic [2:0] lat;
      logic [ADDR_W-1:0] addr;
      logic [31:0] exp;
   } fri_row_t;
   localparam fri_row_t ROWS [5] = '{'{1'b0, 3'h0, 18'h0_0008, 32'h0001_0001},
      '{1'b1, 3'h1, 18'h0_0010, 32'hFFFF_FFFF}, '{1'b0, 3'h2, 18'h0_001C, 32'h0003_0003},
      '{1'b1, 3'h2, 18'h0_0018, 32'h0003_0003}, '{1'b1, 3'h0, 18'h0_001C, 32'h0003_0003}};
   logic clock, reset, ifetch_req, ifetch_ready, dfetch_req, dfetch_write, dfetch_ready;
   logic dfetch_error, acr_wr, key_wr, key_error, ctrl_wr, locked, option_reload_trigger;
   logic ear_wr, clr_eop, clr_programming_error_flag, clr_wrperr, busy_flag, end_of_operation_flag, er;
   logic programming_error_flag, write_protect_error_flag, arr_rd_en, arr_prog, arr_done;
   logic arr_page_erase, arr_mass_erase;
   logic [ADDR_W-1:0] ifetch_addr, dfetch_addr, ear_wdata;
   logic [31:0] ifetch_rdata, dfetch_wdata, dfetch_rdata, key_wdata, rd;
   logic [1:0] dfetch_size;
   logic [ACR_W-1:0] acr_wdata, acr_value;
   logic [CR_W-1:0] ctrl_wdata, ctrl_value;
   logic [SECT_COUNT-1:0] wrp_sector;
   logic [WADDR_W-1:0] arr_addr;
   logic [BLK_W-1:0] arr_rdata;
   logic [ADDR_W-2:0] arr_prog_addr;
   logic [15:0] arr_prog_data;
   logic [PAGE_W-1:0] arr_erase_page;
   logic [32:0] pd;
   logic [8:0] pe;
   int err_total, check_count;
   fri_flash_if dut (.*);
   fri_array_model #(.DONE_WAIT(20)) arr_i (.*);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ---
   // Tasks
   // ---
   task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chk
   task grab;
      if (arr_prog === 1'b1) pd = {arr_prog_addr, arr_prog_data};
      if ((arr_page_erase | arr_mass_erase) === 1'b1) begin
         pe = {arr_mass_erase, arr_page_erase, arr_erase_page};
      end
   endtask : grab
   task acc(input logic ins, input logic w, input logic [1:0] sz,
      input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(negedge clock);
      {ifetch_req, dfetch_req, dfetch_write, dfetch_size} = {ins, !ins, w, sz};
      {ifetch_addr, dfetch_addr, dfetch_wdata} = {a, a, d};
      for (int n = 0; n < 400 && (ins ? ifetch_ready : dfetch_ready) !== 1'b1; n++) begin
         grab();
         @(negedge clock);
      end
      rd = ins ? ifetch_rdata : dfetch_rdata;
      er = dfetch_error;
      {ifetch_req, dfetch_req} = 2'h0;
   endtask : acc
   task pw(input int k, input logic [31:0] d);
      @(negedge clock);
      {acr_wr, key_wr, ctrl_wr, ear_wr} = {k == 0, k == 1, k == 2, k == 3};
      {clr_eop, clr_programming_error_flag, clr_wrperr} = {3{k == 4}};
      {acr_wdata, key_wdata, ctrl_wdata, ear_wdata} = {d[7:0], d, d[15:0], d[17:0]};
      @(negedge clock);
      {acr_wr, key_wr, ctrl_wr, ear_wr, clr_eop, clr_programming_error_flag, clr_wrperr} = 7'h00;
   endtask : pw
   task idle;
      @(negedge clock);
      for (int n = 0; n < 400 && busy_flag !== 1'b0; n++) begin
         grab();
         @(negedge clock);
      end
   endtask : idle
   task results;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   // ---
   // Main sequence
   // ---
   initial begin
      {reset, ifetch_req, dfetch_req, acr_wr, key_wr, ctrl_wr, ear_wr} = 7'h40;
      {clr_eop, clr_programming_error_flag, clr_wrperr, dfetch_write, dfetch_size} = 5'h00;
      {ifetch_addr, dfetch_addr, ear_wdata, dfetch_wdata, key_wdata} = '0;
      {acr_wdata, ctrl_wdata, wrp_sector} = '0;
      repeat (5) @(negedge clock);
      reset = 1'b0;
      chk(acr_value, ACR_RESET, "acr");
      chk({locked, busy_flag, end_of_operation_flag}, 3'h4, "rst");
      $display("Test reset done");
      foreach (ROWS[i]) begin
         pw(0, {29'h0, ROWS[i].lat} | 32'h0000_0010);
         acc(ROWS[i].ins, 1'b0, 2'h2, ROWS[i].addr, 32'h0000_0000);
         chk(rd, ROWS[i].exp, "read");
      end
      pw(0, 32'h0000_0010);
      $display("Test reads done");
      pw(2, 32'h0000_2001);
      chk(option_reload_trigger, 1'b1, "rld");
      chk(ctrl_value, CR_RESET, "lkcr");
      pw(1, FIRST_UNLOCK_KEY);
      pw(1, 32'h0000_1111);
      chk(key_error, 1'b1, "bkey");
      pw(1, FIRST_UNLOCK_KEY);
      pw(1, SECOND_UNLOCK_KEY);
      chk(locked, 1'b1, "dead");
      reset = 1'b1;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      pw(1, FIRST_UNLOCK_KEY);
      pw(1, SECOND_UNLOCK_KEY);
      chk(locked, 1'b0, "open");
      $display("Test keys done");
      pw(2, 32'h0000_0001);
      acc(1'b0, 1'b1, SIZE_HALF, 18'h0_0012, 32'h5678_0000);
      acc(1'b0, 1'b0, 2'h2, 18'h0_0008, 32'h0000_0000);
      chk({rd, end_of_operation_flag, busy_flag}, {32'h0001_0001, 2'h2}, "stal");
      chk(pd, {17'h0_0009, 16'h5678}, "lane");
      pw(4, 32'h0000_0000);
      chk(end_of_operation_flag, 1'b0, "eclr");
      acc(1'b0, 1'b1, SIZE_HALF, 18'h0_0008, 32'h0000_00AB);
      idle();
      chk({programming_error_flag, end_of_operation_flag}, 2'h2, "pger");
      pw(4, 32'h0000_0000);
      acc(1'b0, 1'b1, SIZE_HALF, 18'h0_0008, 32'h0000_0000);
      idle();
      chk({programming_error_flag, end_of_operation_flag}, 2'h1, "zero");
      pw(4, 32'h0000_0000);
      for (int s = 0; s < 3; s += 2) begin
         acc(1'b0, 1'b1, 2'(s), 18'h0_0010, 32'h0000_0000);
         chk(er, 1'b1, "size");
      end
      wrp_sector = 32'h0000_0001;
      acc(1'b0, 1'b1, SIZE_HALF, 18'h0_0020, 32'h0000_1111);
      idle();
      chk({write_protect_error_flag, end_of_operation_flag}, 2'h2, "wrp");
      wrp_sector = 32'h0000_0000;
      pw(4, 32'h0000_0000);
      $display("Test program done");
      pw(3, 32'h0000_1800);
      pw(2, 32'h0000_0042);
      pw(2, 32'h0000_0001);
      idle();
      chk(ctrl_value, 16'h0002, "bsyw");
      chk({pe, end_of_operation_flag}, {9'h083, 1'b1}, "page");
      pw(4, 32'h0000_0000);
      pw(2, 32'h0000_0044);
      idle();
      chk({pe[8], end_of_operation_flag}, 2'h3, "mass");
      pw(2, 32'h0000_0080);
      chk(locked, 1'b1, "relk");
      $display("Test erase done");
      results();
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      results();
   end
endmodule : tb_flash_read_and_program_interface
